// File: pkg/spf_defines.vh
`ifndef SPF_DEFINES_VH
`define SPF_DEFINES_VH
`define SPF_CFG_ADDR 8'h16
`define SPF_CFG_RESET 8'h00
`define SPF_WAKE_POWER_MODE_HI 7
`define SPF_WAKE_POWER_MODE_LO 6
`define SPF_SLEEP_POWER_MODE_HI 5
`define SPF_SLEEP_POWER_MODE_LO 4
`define SPF_ENDIAN_BIT 3
`define SPF_RSVD_BIT 2
`define SPF_TEMP_AINC_BIT 1
`define SPF_FAST_READ_BIT 0
`define SPF_PM_LOW_POWER 2'h0
`define SPF_PM_HIGH_PERF 2'h1
`define SPF_FLEX_BIT 1
`define SPF_RATE_WAKE_HI 7
`define SPF_RATE_WAKE_LO 4
`define SPF_RATE_SLEEP_HI 3
`define SPF_RATE_SLEEP_LO 0
`define SPF_DEC_CODE_MAX 4'hC
`define SPF_BASE_PERIOD_PS 312500000
`define SPF_CLK_PERIOD_PS 8000
`define SPF_TEMP_ADDR 8'h01
`define SPF_OUT_FIRST 8'h04
`define SPF_OUT_LAST 8'h09
`define SPF_BUF_FIRST 8'h1A
`define SPF_BUF_LAST 8'h1F
`endif

// File: hdl/spf_power_format.v
`timescale 1ns/1ps
`include "spf_defines.vh"
module spf_power_format #(
  parameter BASE_PERIOD_PS = `SPF_BASE_PERIOD_PS,
  parameter CLK_PERIOD_PS = `SPF_CLK_PERIOD_PS
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire [7:0] state_rate_config,
  input wire [11:0] wake_idle,
  input wire [11:0] sleep_idle,
  input wire sleep_state,
  input wire sampling_enable,
  input wire boot_mode_pin,
  input wire [11:0] fmt_sample,
  input wire fmt_endian_capable,
  input wire fmt_load,
  output reg [7:0] fmt_low_byte,
  output reg [7:0] fmt_high_byte,
  input wire [7:0] burst_addr,
  input wire burst_step,
  output reg [7:0] burst_next_addr,
  output reg [1:0] wake_power_mode,
  output reg [1:0] sleep_power_mode,
  output reg endian_select,
  output reg temperature_autoinc,
  output reg fast_read,
  output reg wake_flexible,
  output reg sleep_flexible,
  output reg [3:0] wake_rate_code,
  output reg [3:0] wake_decimation_code,
  output reg [3:0] sleep_rate_code,
  output reg [3:0] sleep_decimation_code,
  output reg [25:0] flex_period_units,
  output reg flex_sample_tick,
  output reg power_mode_not_advised
);

  reg [7:0] cfg;
  reg boot_meta;
  reg boot_sync;
  reg [31:0] base_acc;
  reg base_tick;
  reg [25:0] period_cnt;
  reg [25:0] next_period;
  reg [3:0] cur_dec_code;
  reg [12:0] dec_factor;
  reg [11:0] cur_idle;
  reg cur_flex;
  reg [7:0] next_low;
  reg [7:0] next_high;
  reg [7:0] next_addr;
  reg in_data;
  wire [1:0] cfg_wake_power_mode = cfg[`SPF_WAKE_POWER_MODE_HI:`SPF_WAKE_POWER_MODE_LO];
  wire [1:0] cfg_sleep_power_mode = cfg[`SPF_SLEEP_POWER_MODE_HI:`SPF_SLEEP_POWER_MODE_LO];
  wire cfg_wake_flex = cfg_wake_power_mode[`SPF_FLEX_BIT];
  wire cfg_sleep_flex = cfg_sleep_power_mode[`SPF_FLEX_BIT];
  wire [3:0] wake_nibble = state_rate_config[`SPF_RATE_WAKE_HI:`SPF_RATE_WAKE_LO];
  wire [3:0] sleep_nibble = state_rate_config[`SPF_RATE_SLEEP_HI:`SPF_RATE_SLEEP_LO];
  wire [31:0] acc_sum = base_acc + CLK_PERIOD_PS;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= `SPF_CFG_RESET;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `SPF_CFG_ADDR) begin
        cfg <= reg_wdata;
      end
      if (reg_rd) begin
        reg_rdata <= (reg_addr == `SPF_CFG_ADDR) ? cfg : 8'h00;
      end
    end
  end

  // current state picks its own idle and decimation
  always @* begin
    cur_flex = sleep_state ? cfg_sleep_flex : cfg_wake_flex;
    cur_dec_code = sleep_state ? sleep_nibble : wake_nibble;
    cur_idle = sleep_state ? sleep_idle : wake_idle;
    // codes above the largest factor saturate rather than overflow
    if (cur_dec_code > `SPF_DEC_CODE_MAX) begin
      cur_dec_code = `SPF_DEC_CODE_MAX;
    end
    dec_factor = 13'h0001 << cur_dec_code;
    next_period = ({14'h0000, cur_idle} + 26'h0000001) * {13'h0000, dec_factor};
  end

  always @* begin
    if (cfg[`SPF_FAST_READ_BIT]) begin
      next_low = fmt_sample[11:4];
      next_high = 8'h00;
    end else if (cfg[`SPF_ENDIAN_BIT] && fmt_endian_capable) begin
      next_low = fmt_sample[11:4];
      next_high = {fmt_sample[3:0], 4'h0};
    end else begin
      next_low = fmt_sample[7:0];
      next_high = {4'h0, fmt_sample[11:8]};
    end
  end

  // burst pointer advance
  always @* begin
    in_data = (burst_addr >= `SPF_OUT_FIRST && burst_addr <= `SPF_OUT_LAST) ||
              (burst_addr >= `SPF_BUF_FIRST && burst_addr <= `SPF_BUF_LAST);
    next_addr = burst_addr + 8'h01;
    if (cfg[`SPF_FAST_READ_BIT] && in_data) begin
      next_addr = burst_addr + 8'h02;
    end
    if (!cfg[`SPF_TEMP_AINC_BIT] && next_addr == `SPF_TEMP_ADDR) begin
      next_addr = next_addr + 8'h01;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fmt_low_byte <= 8'h00;
      fmt_high_byte <= 8'h00;
      burst_next_addr <= 8'h00;
    end else begin
      if (fmt_load) begin
        fmt_low_byte <= next_low;
        fmt_high_byte <= next_high;
      end
      if (burst_step) begin
        burst_next_addr <= next_addr;
      end
    end
  end

  // nibble as decimation in flexible mode
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_power_mode <= `SPF_PM_LOW_POWER;
      sleep_power_mode <= `SPF_PM_LOW_POWER;
      endian_select <= 1'b0;
      temperature_autoinc <= 1'b0;
      fast_read <= 1'b0;
      wake_flexible <= 1'b0;
      sleep_flexible <= 1'b0;
      wake_rate_code <= 4'h0;
      wake_decimation_code <= 4'h0;
      sleep_rate_code <= 4'h0;
      sleep_decimation_code <= 4'h0;
      flex_period_units <= 26'h0000000;
    end else begin
      wake_power_mode <= cfg_wake_power_mode;
      sleep_power_mode <= cfg_sleep_power_mode;
      endian_select <= cfg[`SPF_ENDIAN_BIT];
      temperature_autoinc <= cfg[`SPF_TEMP_AINC_BIT];
      fast_read <= cfg[`SPF_FAST_READ_BIT];
      wake_flexible <= cfg_wake_flex;
      sleep_flexible <= cfg_sleep_flex;
      wake_rate_code <= cfg_wake_flex ? 4'h0 : wake_nibble;
      wake_decimation_code <= cfg_wake_flex ? wake_nibble : 4'h0;
      sleep_rate_code <= cfg_sleep_flex ? 4'h0 : sleep_nibble;
      sleep_decimation_code <= cfg_sleep_flex ? sleep_nibble : 4'h0;
      flex_period_units <= cur_flex ? next_period : 26'h0000000;
    end
  end

  // base tick by fractional accumulator, exact on average for a non-integer cycle count
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      base_acc <= 32'h00000000;
      base_tick <= 1'b0;
    end else if (!(sampling_enable && cur_flex)) begin
      base_acc <= 32'h00000000;
      base_tick <= 1'b0;
    end else if (acc_sum >= BASE_PERIOD_PS) begin
      base_acc <= acc_sum - BASE_PERIOD_PS;
      base_tick <= 1'b1;
    end else begin
      base_acc <= acc_sum;
      base_tick <= 1'b0;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      period_cnt <= 26'h0000000;
      flex_sample_tick <= 1'b0;
    end else if (!(sampling_enable && cur_flex)) begin
      period_cnt <= 26'h0000000;
      flex_sample_tick <= 1'b0;
    end else if (base_tick) begin
      if (period_cnt + 26'h0000001 >= next_period) begin
        period_cnt <= 26'h0000000;
        flex_sample_tick <= 1'b1;
      end else begin
        period_cnt <= period_cnt + 26'h0000001;
        flex_sample_tick <= 1'b0;
      end
    end else begin
      flex_sample_tick <= 1'b0;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_meta <= 1'b0;
      boot_sync <= 1'b0;
      power_mode_not_advised <= 1'b0;
    end else begin
      boot_meta <= boot_mode_pin;
      boot_sync <= boot_meta;
      power_mode_not_advised <= boot_sync &&
        (cfg_wake_power_mode != `SPF_PM_LOW_POWER || cfg_sleep_power_mode != `SPF_PM_LOW_POWER);
    end
  end

endmodule

// File: test/spf_power_format_props.sv
`timescale 1ns/1ps
module spf_power_format_props (
  input wire sys_clk,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [11:0] fmt_sample,
  input wire fmt_endian_capable,
  input wire fmt_load,
  input wire [7:0] fmt_low_byte,
  input wire [7:0] fmt_high_byte,
  input wire [7:0] burst_addr,
  input wire burst_step,
  input wire [7:0] burst_next_addr,
  input wire endian_select,
  input wire temperature_autoinc,
  input wire fast_read,
  input wire sampling_enable,
  input wire boot_mode_pin,
  input wire flex_sample_tick,
  input wire power_mode_not_advised
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_reset_zero: assert property ($rose(rst_b) |-> reg_rdata == 8'h00 && !fast_read) else $error("not zero");
  a_unmapped_read: assert property (reg_rd && reg_addr != 8'h16 |=> reg_rdata == 8'h00) else $error("bad rdata");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
  a_fast_fmt: assert property (fmt_load && fast_read |=> fmt_low_byte == $past(fmt_sample[11:4])
    && fmt_high_byte == 8'h00) else $error("fast fmt");
  a_little_fmt: assert property (fmt_load && !fast_read && !(endian_select && fmt_endian_capable) |=>
    {fmt_high_byte, fmt_low_byte} == {4'h0, $past(fmt_sample)}) else $error("le fmt");
  a_big_fmt: assert property (fmt_load && !fast_read && endian_select && fmt_endian_capable |=>
    {fmt_low_byte, fmt_high_byte} == {$past(fmt_sample), 4'h0}) else $error("be fmt");
  a_burst_temp: assert property (burst_step && burst_addr == 8'h00 && !temperature_autoinc |=>
    burst_next_addr == 8'h02) else $error("temp skip");
  a_burst_fast: assert property (burst_step && fast_read && burst_addr == 8'h04 |=> burst_next_addr == 8'h06)
    else $error("fast skip");
  a_tick_off: assert property (!sampling_enable [*2] |-> !flex_sample_tick) else $error("tick off");
  // two sync stages plus the flag register: the pin must be low for four edges
  a_advise_off: assert property (!boot_mode_pin [*4] |-> !power_mode_not_advised) else $error("advise");
endmodule
bind spf_power_format spf_power_format_props u_props (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .reg_addr(reg_addr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .fmt_sample(fmt_sample),
  .fmt_endian_capable(fmt_endian_capable),
  .fmt_load(fmt_load),
  .fmt_low_byte(fmt_low_byte),
  .fmt_high_byte(fmt_high_byte),
  .burst_addr(burst_addr),
  .burst_step(burst_step),
  .burst_next_addr(burst_next_addr),
  .endian_select(endian_select),
  .temperature_autoinc(temperature_autoinc),
  .fast_read(fast_read),
  .sampling_enable(sampling_enable),
  .boot_mode_pin(boot_mode_pin),
  .flex_sample_tick(flex_sample_tick),
  .power_mode_not_advised(power_mode_not_advised)
);

// File: test/spf_host_model.sv
`timescale 1ns/1ps
module spf_host_model (
  input wire sys_clk,
  output reg [7:0] reg_addr,
  output reg [7:0] reg_wdata,
  output reg reg_wr,
  output reg reg_rd,
  input wire [7:0] reg_rdata
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
  task wr(input [7:0] a, input [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v & 8'hFB;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, output [7:0] q);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    // data stands from the strobe edge until the next read, so take it one edge later
    @(posedge sys_clk);
    q = reg_rdata;
  endtask
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg sys_clk = 0, rst_b = 0, slp = 0, en = 0, boot = 0, cap = 0, ld = 0, bs = 0;
  reg [7:0] rate = 0, baddr = 0, d, c;
  reg [11:0] idle = 0, smp = 0;
  wire [7:0] ra, wd, rdat, nxt, lo, hi;
  wire [1:0] wpm, spm;
  wire [3:0] wrc, wdc, src, sdc;
  wire [25:0] units;
  wire rw, rr, es, ta, fr, tick, nadv, wf, sf;
  integer fail_count = 0, check_count = 0, cyc = 0, i, t0;
  always #4 sys_clk = ~sys_clk;
  spf_host_model host (.sys_clk(sys_clk), .reg_addr(ra), .reg_wdata(wd), .reg_wr(rw), .reg_rd(rr), .reg_rdata(rdat));
  spf_power_format #(.BASE_PERIOD_PS(80000)) DUT (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(ra), .reg_wdata(wd),
    .reg_wr(rw), .reg_rd(rr), .reg_rdata(rdat), .state_rate_config(rate), .wake_idle(idle), .sleep_idle(idle),
    .sleep_state(slp), .sampling_enable(en), .boot_mode_pin(boot), .fmt_sample(smp), .fmt_endian_capable(cap),
    .fmt_load(ld), .fmt_low_byte(lo), .fmt_high_byte(hi), .burst_addr(baddr), .burst_step(bs),
    .burst_next_addr(nxt), .wake_power_mode(wpm), .sleep_power_mode(spm), .endian_select(es),
    .temperature_autoinc(ta), .fast_read(fr), .wake_flexible(wf), .sleep_flexible(sf), .wake_rate_code(wrc),
    .wake_decimation_code(wdc), .sleep_rate_code(src), .sleep_decimation_code(sdc), .flex_period_units(units),
    .flex_sample_tick(tick), .power_mode_not_advised(nadv));
  task chk(input [31:0] seen, input [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function [31:0] exp_units(input [7:0] k);
    reg [3:0] dc;
    dc = slp ? rate[3:0] : rate[7:4];
    exp_units = (slp ? k[5] : k[7]) ? (idle + 1) << (dc > 12 ? 12 : dc) : 0;
  endfunction
  function [7:0] exp_next(input [7:0] k, input [7:0] a);
    exp_next = a + ((k[0] && ((a >= 4 && a <= 9) || (a >= 8'h1A && a <= 8'h1F))) ? 2 : 1);
    if (!k[1] && exp_next == 8'h01) exp_next = 8'h02;
  endfunction
  // tick is looked at mid-cycle, where it has settled
  task wait_tick;
    integer k;
    @(negedge sys_clk);
    for (k = 0; k < 300 && tick !== 1'b1; k = k + 1) @(negedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      print_verdict;
    end
  end
  initial begin
    d = $urandom(32167);
    repeat (20) @(posedge sys_clk);
    rst_b <= 1;
    host.rd(8'h16, d);
    chk(d, 0);
    for (i = 0; i < 40; i = i + 1) begin
      c = $urandom & 8'hFB;
      {rate, smp, cap, boot, slp} <= {$urandom, $urandom};
      idle <= $urandom % 8;
      host.wr(8'h16, c | 8'h04);
      host.wr(8'h20, 8'hFF);
      repeat (3) @(posedge sys_clk);
      host.rd(8'h16, d);
      chk(d, c);
      host.rd(8'h20, d);
      chk(d, 0);
      chk({wpm, spm, es, ta, fr}, {c[7:3], c[1:0]});
      chk({wrc, wdc}, c[7] ? {4'h0, rate[7:4]} : {rate[7:4], 4'h0});
      chk({src, sdc}, c[5] ? {4'h0, rate[3:0]} : {rate[3:0], 4'h0});
      chk(units, exp_units(c));
      chk({wf, sf}, {c[7], c[5]});
      chk(nadv, boot && c[7:4] != 0);
      ld <= 1;
      bs <= 1;
      baddr <= $urandom % 12 + (i[0] ? 8'h16 : 8'h00);
      @(posedge sys_clk);
      {ld, bs} <= 2'b00;
      @(posedge sys_clk);
      chk({lo, hi}, c[0] ? {smp[11:4], 8'h00} : (c[3] && cap) ? {smp, 4'h0} : {smp[7:0], 4'h0, smp[11:8]});
      chk(nxt, exp_next(c, baddr));
    end
    $display("config test done");
    {rate, idle, slp, en} <= {8'h10, 12'h001, 2'b01};
    host.wr(8'h16, 8'h80);
    wait_tick;
    t0 = $time;
    wait_tick;
    chk(($time - t0) / 8, 40);
    $display("tick test done");
    print_verdict;
  end
endmodule
